// ==== twb_pkg.sv ====
// shared constants and types for the two-wire addressed serial bus
// assumes both ends run on one 25 MHz system clock
`default_nettype none
package twb_pkg;
  // word framing
  localparam int WORD_BITS = 8;
  localparam logic [3:0] ACK_POS = 4'h8; // clock index of ack slot
  localparam logic [3:0] BUSY_POS = 4'h9; // first clock of busy check
  // serial clock generated by the master end
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_HALF_NS = 160; // half period of the serial clock
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_POS = 4'h0;
  // master request kinds
  typedef enum logic [1:0] {
    TWB_OP_WORD,
    TWB_OP_REL,
    TWB_OP_CMD
  } twb_op_t;
  // classification of a received word
  typedef enum logic [1:0] {
    TWB_K_ADDR,
    TWB_K_CMD,
    TWB_K_DATA
  } twb_kind_t;
endpackage
`default_nettype wire

// ==== twb_if.sv ====
// carrier joining master end and slave end over the two bus lines
// assumes open-drain data: a low enable with low output pulls the line
`default_nettype none
interface twb_if;
  logic scl; // serial clock, made by the master end
  logic m_sda_o; // master data output (always low when enabled)
  logic m_sda_oe_b; // master pulls data line while low
  logic s_sda_o; // slave data output
  logic s_sda_oe_b; // slave pulls data line while low
  logic sda; // resolved wired line level, pulled up when idle
  // wired line: any enabled low driver wins
  assign sda = (m_sda_oe_b | m_sda_o) & (s_sda_oe_b | s_sda_o);
  modport master (output scl, output m_sda_o, output m_sda_oe_b,
                  input sda);
  modport slave (input scl, input sda, output s_sda_o,
                 output s_sda_oe_b);
endinterface
`default_nettype wire

// ==== twb_fifo.sv ====
// small synchronous fifo holding received words with their kind
// assumes DEPTH is a power of two so pointers wrap naturally
`default_nettype none
module twb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d; // pointers
  logic [CW-1:0] cnt_q, cnt_d; // fill level
  logic rdy_q, rdy_d, vld_q, vld_d; // registered full/empty views
  logic [WIDTH-1:0] dat_q, dat_d; // head word, held in a flop
  logic push, pop;

  // next pointers and honest flags
  always_comb begin
    push = in_valid_i & rdy_q;
    pop = vld_q & out_ready_i;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    // next head: the incoming word when it lands in that very slot
    dat_d = (push && wr_q == rd_d) ? in_data_i : mem[rd_d];
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    rdy_d = cnt_d != CW'(DEPTH);
    vld_d = cnt_d != '0;
  end

  // registers; storage has no reset, only pointers, count and flags get one
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
    dat_q <= dat_d; // output straight from a flop
  end

  assign in_ready_o = rdy_q;
  assign out_valid_o = vld_q;
  assign out_data_o = dat_q;
endmodule
`default_nettype wire

// ==== twb_master_end.sv ====
// master end: makes the serial clock, conditions and word transfers
// assumes one request at a time on the user side, taken when ready
`default_nettype none
module twb_master_end (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // bus side
  twb_if.master bus,
  // request
  input wire logic cmd_valid_i,
  input wire twb_pkg::twb_op_t cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_ack_i,
  output logic cmd_ready_o,
  // result
  output logic done_o,
  output logic [7:0] rx_data_o,
  output logic ack_seen_o
);
  typedef enum {
    ST_IDLE, ST_PREP_LO, ST_PREP_HI, ST_GAP, ST_LO, ST_HI
  } twb_mst_t;
  twb_mst_t st_q, st_d;
  logic [2:0] tmr_q, tmr_d; // half period timer
  logic scl_q, scl_d; // driven serial clock
  logic pull_q, pull_d; // open-drain pull on data line
  logic [3:0] bit_q, bit_d; // clock index inside the word
  logic [7:0] sh_q, sh_d, rx_q, rx_d;
  logic ack_q, ack_d, ackd_q, ackd_d, done_q, done_d, rdy_q, rdy_d;
  logic sda_m, sda_s; // data line synchroniser
  logic tick;

  // next state of the transfer engine
  always_comb begin
    tick = tmr_q == 3'h0; // needed before the timer reload below
    st_d = st_q;
    tmr_d = tick ? 3'(twb_pkg::SCL_HALF_CYC - 1) : tmr_q - 1'b1;
    scl_d = scl_q;
    pull_d = pull_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rx_d = rx_q;
    ack_d = ack_q;
    ackd_d = ackd_q;
    done_d = 1'b0;
    case (st_q)
      ST_IDLE: begin // clock idles high
        tmr_d = 3'(twb_pkg::SCL_HALF_CYC - 1);
        if (cmd_valid_i) begin
          case (cmd_op_i)
            twb_pkg::TWB_OP_REL: begin // line low first, clock low
              scl_d = 1'b0;
              pull_d = 1'b1;
              st_d = ST_PREP_LO;
            end
            twb_pkg::TWB_OP_CMD: begin // falling data, clock high
              pull_d = 1'b1;
              st_d = ST_GAP;
            end
            default: begin // first bit, msb first
              scl_d = 1'b0;
              pull_d = !cmd_data_i[7];
              sh_d = {cmd_data_i[6:0], 1'b1};
              ack_d = cmd_ack_i;
              bit_d = 4'h0;
              st_d = ST_LO;
            end
          endcase
        end
      end
      ST_PREP_LO: if (tick) begin
        scl_d = 1'b1;
        st_d = ST_PREP_HI;
      end
      ST_PREP_HI: if (tick) begin // rising data, clock high
        pull_d = 1'b0;
        st_d = ST_GAP;
      end
      ST_GAP: if (tick) begin // hold so slaves see the condition
        st_d = ST_IDLE;
        done_d = 1'b1;
      end
      ST_LO: if (tick) begin
        scl_d = 1'b1;
        st_d = ST_HI;
      end
      ST_HI: if (tick) begin // sample just before the falling edge
        if (bit_q < twb_pkg::ACK_POS) begin
          rx_d = {rx_q[6:0], sda_s};
        end
        if (bit_q == twb_pkg::ACK_POS) begin
          ackd_d = !sda_s;
        end
        if (bit_q >= twb_pkg::BUSY_POS && sda_s) begin
          st_d = ST_IDLE; // busy gone: stop the clock
          done_d = 1'b1;
        end else begin // keep clocking through busy
          scl_d = 1'b0;
          st_d = ST_LO;
          if (bit_q < twb_pkg::BUSY_POS) begin
            bit_d = bit_q + 1'b1;
          end
          if (bit_q < 4'h7) begin
            pull_d = !sh_q[7];
            sh_d = {sh_q[6:0], 1'b1};
          end else if (bit_q == 4'h7) begin
            pull_d = ack_q; // one-clock ack when receiving
          end else begin
            pull_d = 1'b0;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    rdy_d = st_d == ST_IDLE && !(st_q == ST_IDLE && cmd_valid_i);
  end

  // registers, synchroniser included
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      tmr_q <= 3'h0;
      scl_q <= 1'b1;
      pull_q <= 1'b0;
      bit_q <= twb_pkg::RST_POS;
      sh_q <= twb_pkg::RST_BYTE;
      rx_q <= twb_pkg::RST_BYTE;
      ack_q <= 1'b0;
      ackd_q <= 1'b0;
      done_q <= 1'b0;
      rdy_q <= 1'b0;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      scl_q <= scl_d;
      pull_q <= pull_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      ack_q <= ack_d;
      ackd_q <= ackd_d;
      done_q <= done_d;
      rdy_q <= rdy_d;
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  // bus pins: open drain, enable low while pulling
  assign bus.scl = scl_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe_b = !pull_q;
  assign cmd_ready_o = rdy_q;
  assign done_o = done_q;
  assign rx_data_o = rx_q;
  assign ack_seen_o = ackd_q;
endmodule
`default_nettype wire

// ==== twb_slave_end.sv ====
// slave end: detects conditions, classifies words, selects by address
// assumes the serial clock is made by the master end and is sampled
// here on the system clock; half period must span at least 4 cycles
`default_nettype none
module twb_slave_end #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // bus side
  twb_if.slave bus,
  // configuration levels
  input wire logic [7:0] own_addr_i,
  input wire logic wake_en_i,
  input wire logic ack_en_i,
  input wire logic busy_en_i,
  // transmit data
  input wire logic tx_en_i,
  input wire logic [7:0] tx_data_i,
  // received word stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output twb_pkg::twb_kind_t rx_kind_o,
  input wire logic rx_ready_i,
  // events and state
  output logic transfer_done_irq_o,
  output logic bus_release_condition_o,
  output logic command_o,
  output logic selected_o,
  output logic ack_seen_o,
  output logic drop_o
);
  // synchronisers: first stage read only by second
  logic scl_m, scl_s, scl_p; // clock line: meta, stable, previous
  logic sda_m, sda_s, sda_p; // data line: meta, stable, previous
  logic rise, fall, rel_det, cmd_det;
  // frame state
  logic [3:0] pos_q, pos_d; // rising edges seen in this word
  logic [7:0] sh_q, sh_d; // receive shift register
  logic [7:0] tx_q, tx_d; // transmit shift register
  logic txw_q, txw_d; // this word is sent by us
  logic rel_q, rel_d; // release seen, address pending
  logic cmd_q, cmd_d; // command signal seen
  logic sel_q, sel_d; // selected by address
  logic pull_q, pull_d; // our pull on the data line
  logic ackw_q, ackw_d; // we owe an ack for this word
  // event outputs
  logic irq_q, irq_d, relo_q, relo_d, cmdo_q, cmdo_d;
  logic ackd_q, ackd_d, drop_q, drop_d;
  // word completion
  logic [7:0] word;
  twb_pkg::twb_kind_t kind;
  logic match, keep, push, fifo_rdy, busy_want;
  logic [9:0] fifo_out;

  // edge and condition detection on stable samples only
  always_comb begin
    rise = scl_s & !scl_p;
    fall = !scl_s & scl_p;
    rel_det = scl_s & scl_p & sda_s & !sda_p;
    cmd_det = scl_s & scl_p & !sda_s & sda_p;
  end

  // word classification at the eighth rising edge
  always_comb begin
    word = {sh_q[6:0], sda_s};
    if (rel_q) begin
      kind = twb_pkg::TWB_K_ADDR;
    end else if (cmd_q) begin
      kind = twb_pkg::TWB_K_CMD;
    end else begin
      kind = twb_pkg::TWB_K_DATA;
    end
    match = word == own_addr_i;
    // with wake-up on, a deselected slave ignores the traffic
    if (kind == twb_pkg::TWB_K_ADDR) begin
      keep = match || !wake_en_i;
    end else begin
      keep = sel_q || !wake_en_i;
    end
    push = rise && pos_q == 4'h7 && keep && !txw_q;
    // busy also stalls the master while selected and the fifo has no room
    busy_want = sel_q && (busy_en_i || !fifo_rdy);
  end

  // next frame state
  always_comb begin
    pos_d = pos_q;
    sh_d = sh_q;
    tx_d = tx_q;
    txw_d = txw_q;
    rel_d = rel_q;
    cmd_d = cmd_q;
    sel_d = sel_q;
    pull_d = pull_q;
    ackw_d = ackw_q;
    irq_d = 1'b0;
    relo_d = rel_det;
    cmdo_d = cmd_det;
    ackd_d = ackd_q;
    drop_d = push && !fifo_rdy;
    if (rel_det) begin // new frame, address follows
      rel_d = 1'b1;
      cmd_d = 1'b0;
      pos_d = twb_pkg::RST_POS;
      pull_d = 1'b0;
    end else if (cmd_det) begin
      cmd_d = 1'b1; // after a release the word stays an address
      pos_d = twb_pkg::RST_POS;
      pull_d = 1'b0;
    end else if (rise) begin // sample on rising edge
      if (pos_q < twb_pkg::ACK_POS) begin
        sh_d = word;
        pos_d = pos_q + 1'b1;
      end else if (pos_q == twb_pkg::ACK_POS) begin
        ackd_d = txw_q ? !sda_s : ackd_q; // receiver's ack
        pos_d = pos_q + 1'b1;
      end else if (sda_s) begin
        pos_d = twb_pkg::RST_POS; // busy over, next word may start
      end
      if (pos_q == 4'h7) begin // eighth bit just taken
        rel_d = 1'b0;
        cmd_d = 1'b0;
        ackw_d = keep && ack_en_i && !txw_q;
        if (kind == twb_pkg::TWB_K_ADDR) begin
          sel_d = match; // held until the next address
          irq_d = match || !wake_en_i;
        end else begin
          irq_d = !wake_en_i;
        end
      end
    end else if (fall) begin // drive on falling edge
      if (pos_q == twb_pkg::RST_POS) begin
        txw_d = tx_en_i && sel_q && !rel_q && !cmd_q;
        pull_d = tx_en_i && sel_q && !rel_q && !cmd_q
                 && !tx_data_i[7];
        tx_d = {tx_data_i[6:0], 1'b1};
      end else if (pos_q < twb_pkg::ACK_POS) begin
        pull_d = txw_q && !tx_q[7]; // released bits stay high
        tx_d = {tx_q[6:0], 1'b1};
      end else if (pos_q == twb_pkg::ACK_POS) begin
        pull_d = ackw_q; // one clock of ack
      end else begin
        pull_d = busy_want; // busy set and freed on falls
      end
    end
  end

  // registers of the slave end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      pos_q <= twb_pkg::RST_POS;
      sh_q <= twb_pkg::RST_BYTE;
      tx_q <= twb_pkg::RST_BYTE;
      txw_q <= 1'b0;
      rel_q <= 1'b0;
      cmd_q <= 1'b0;
      sel_q <= 1'b0;
      pull_q <= 1'b0;
      ackw_q <= 1'b0;
      irq_q <= 1'b0;
      relo_q <= 1'b0;
      cmdo_q <= 1'b0;
      ackd_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
      pos_q <= pos_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      txw_q <= txw_d;
      rel_q <= rel_d;
      cmd_q <= cmd_d;
      sel_q <= sel_d;
      pull_q <= pull_d;
      ackw_q <= ackw_d;
      irq_q <= irq_d;
      relo_q <= relo_d;
      cmdo_q <= cmdo_d;
      ackd_q <= ackd_d;
      drop_q <= drop_d;
    end
  end

  // received words wait here; a full fifo holds busy on the bus while selected
  twb_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .in_data_i({kind, word}),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(fifo_out)
  );

  // open-drain data pin, enable low while pulling
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe_b = !pull_q;
  assign rx_data_o = fifo_out[7:0];
  assign rx_kind_o = twb_pkg::twb_kind_t'(fifo_out[9:8]);
  assign transfer_done_irq_o = irq_q;
  assign bus_release_condition_o = relo_q;
  assign command_o = cmdo_q;
  assign selected_o = sel_q;
  assign ack_seen_o = ackd_q;
  assign drop_o = drop_q;
endmodule
`default_nettype wire

// ==== twb_checker.sv ====
// checker on the two bus lines between master end and slave end
// assumes it sees the interface signals on the shared system clock
`default_nettype none
module twb_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // bus lines
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_b,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_b,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // clock high over two samples: no bit is being shifted
  sequence s_idle_hi;
    scl && $past(scl);
  endsequence
  // data rises under an idle clock
  sequence s_rel;
    s_idle_hi ##0 $rose(sda);
  endsequence
  // data falls under an idle clock
  sequence s_cmd;
    s_idle_hi ##0 $fell(sda);
  endsequence
  property p_m_od;
    !m_sda_oe_b |-> !m_sda_o;
  endproperty
  a_m_od: assert property (p_m_od)
    else $error("master end drives the data line high");
  property p_s_od;
    !s_sda_oe_b |-> !s_sda_o;
  endproperty
  a_s_od: assert property (p_s_od)
    else $error("slave end drives the data line high");
  // slave moves its pull only while the clock is low
  property p_s_chg_low;
    $changed(s_sda_oe_b) |-> !scl;
  endproperty
  a_s_chg_low: assert property (p_s_chg_low)
    else $error("slave changed data with clock high");
  property p_scl_half;
    $changed(scl) |=> $stable(scl)[*3];
  endproperty
  a_scl_half: assert property (p_scl_half)
    else $error("serial clock half period too short");
  // a held busy must never leave the clock parked high
  property p_busy_clk;
    (!s_sda_oe_b && scl) |-> ##[1:4] !scl;
  endproperty
  a_busy_clk: assert property (p_busy_clk)
    else $error("clock stopped while slave pulls the line");
  // synchroniser delay: slave cannot react at once to a fall
  property p_s_sync;
    $fell(scl) |-> $stable(s_sda_oe_b)[*2];
  endproperty
  a_s_sync: assert property (p_s_sync)
    else $error("slave reacted to clock fall too early");
  property p_rel;
    s_rel |-> $rose(m_sda_oe_b);
  endproperty
  a_rel: assert property (p_rel)
    else $error("release edge not made by the master end");
  property p_cmd;
    s_cmd |-> $fell(m_sda_oe_b);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command edge not made by the master end");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// bench joining master end and slave end over one carrier
// assumes a 25 MHz clock and that the slave holds the received-word fifo
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i, rst_b_i; // system clock, reset
  logic cmd_valid_i, cmd_ack_i, cmd_ready_o, done_o, m_ack; // master user
  twb_pkg::twb_op_t cmd_op_i;
  logic [7:0] cmd_data_i, m_rx, own_addr_i, tx_data_i, rx_data_o, seen;
  logic wake_en_i, ack_en_i, busy_en_i, tx_en_i, rx_valid_o, rx_ready_i;
  twb_pkg::twb_kind_t rx_kind_o;
  logic irq, bus_release_condition, cmdc, sel, s_ack, drop; // slave events
  int errors = 0, num_checks = 0, nbits = 0, nb, n_irq = 0, n_rel = 0;
  int n_cmd = 0, n_drop = 0, base;
  logic got_done;
  twb_if i_twb_if ();
  twb_master_end i_twb_master_end (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .bus(i_twb_if), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_data_i(cmd_data_i), .cmd_ack_i(cmd_ack_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rx_data_o(m_rx),
    .ack_seen_o(m_ack));
  twb_slave_end i_twb_slave_end (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .bus(i_twb_if), .own_addr_i(own_addr_i), .wake_en_i(wake_en_i),
    .ack_en_i(ack_en_i), .busy_en_i(busy_en_i), .tx_en_i(tx_en_i),
    .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_kind_o(rx_kind_o), .rx_ready_i(rx_ready_i),
    .transfer_done_irq_o(irq), .bus_release_condition_o(bus_release_condition),
    .command_o(cmdc), .selected_o(sel), .ack_seen_o(s_ack), .drop_o(drop));
  twb_checker i_twb_checker (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .scl(i_twb_if.scl), .m_sda_o(i_twb_if.m_sda_o),
    .m_sda_oe_b(i_twb_if.m_sda_oe_b), .s_sda_o(i_twb_if.s_sda_o),
    .s_sda_oe_b(i_twb_if.s_sda_oe_b), .sda(i_twb_if.sda));
  // free-running system clock
  always #20 clock_i = ~clock_i;
  // event pulses counted so no single cycle can be missed
  always @(posedge clock_i) begin
    if (irq === 1'b1) n_irq++;
    if (bus_release_condition === 1'b1) n_rel++;
    if (cmdc === 1'b1) n_cmd++;
    if (drop === 1'b1) n_drop++;
  end
  // line level at each clock rise, first eight kept msb first
  always @(posedge i_twb_if.scl) begin
    if (nbits < 8) seen = {seen[6:0], i_twb_if.sda};
    nbits++;
  end
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a wait that ran out counts as a mismatch
  task automatic hang();
    errors++;
    tally_and_finish();
  endtask
  // one master request, held until taken, then waits for done
  task automatic m_req(input twb_pkg::twb_op_t op, input logic [7:0] d,
                       input logic ack);
    int n;
    @(negedge clock_i);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_data_i = d;
    cmd_ack_i = ack;
    nbits = 0;
    got_done = 1'b0;
    for (n = 0; cmd_ready_o !== 1'b1; n++) begin
      if (n > 200) hang();
      @(negedge clock_i);
    end
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    for (n = 0; done_o !== 1'b1; n++) begin
      if (n > 3000) hang();
      @(negedge clock_i);
    end
    got_done = 1'b1;
  endtask
  // take one word from the slave stream and compare it
  task automatic pop(input twb_pkg::twb_kind_t k, input logic [7:0] d);
    int n;
    for (n = 0; rx_valid_o !== 1'b1; n++) begin
      if (n > 200) hang();
      @(negedge clock_i);
    end
    chk("kind", 8'(rx_kind_o), 8'(k));
    chk("word", rx_data_o, d);
    rx_ready_i = 1'b1;
    @(negedge clock_i);
    rx_ready_i = 1'b0;
    @(negedge clock_i); // an edge passes before the next pop raises it
  endtask
  // main sequence
  initial begin
    clock_i = 1'b0;
    rst_b_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = twb_pkg::TWB_OP_WORD;
    cmd_data_i = 8'h00;
    cmd_ack_i = 1'b0;
    own_addr_i = 8'h5a;
    wake_en_i = 1'b0;
    ack_en_i = 1'b1;
    busy_en_i = 1'b0;
    tx_en_i = 1'b0;
    tx_data_i = 8'ha5;
    rx_ready_i = 1'b0;
    repeat (6) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk("idle line", i_twb_if.sda, 8'h01);
    chk("sel at reset", sel, 8'h00);
    // release then own address
    m_req(twb_pkg::TWB_OP_REL, 8'h00, 1'b0);
    chk("release", 8'(n_rel), 8'h01);
    m_req(twb_pkg::TWB_OP_WORD, 8'h5a, 1'b0);
    chk("addr bits", seen, 8'h5a);
    chk("irq", 8'(n_irq), 8'h01);
    chk("selected", sel, 8'h01);
    chk("slave ack", m_ack, 8'h01);
    pop(twb_pkg::TWB_K_ADDR, 8'h5a);
    // command condition then command word
    m_req(twb_pkg::TWB_OP_CMD, 8'h00, 1'b0);
    chk("command", 8'(n_cmd), 8'h01);
    m_req(twb_pkg::TWB_OP_WORD, 8'h3c, 1'b0);
    pop(twb_pkg::TWB_K_CMD, 8'h3c);
    // plain words of both bit extremes
    for (int i = 0; i < 2; i++) begin
      m_req(twb_pkg::TWB_OP_WORD, i ? 8'h81 : 8'h7e, 1'b0);
      chk("data bits", seen, i ? 8'h81 : 8'h7e);
      pop(twb_pkg::TWB_K_DATA, i ? 8'h81 : 8'h7e);
    end
    chk("still selected", sel, 8'h01);
    // slave sends, master released line and acks
    tx_en_i = 1'b1; // slave's send slot fixed in advance
    m_req(twb_pkg::TWB_OP_WORD, 8'hff, 1'b1);
    tx_en_i = 1'b0;
    chk("master rx", m_rx, 8'ha5);
    chk("master ack", s_ack, 8'h01);
    chk("no self push", rx_valid_o, 8'h00);
    // another address deselects
    m_req(twb_pkg::TWB_OP_REL, 8'h00, 1'b0);
    m_req(twb_pkg::TWB_OP_WORD, 8'h11, 1'b0);
    chk("deselected", sel, 8'h00);
    pop(twb_pkg::TWB_K_ADDR, 8'h11);
    // wake-up: only a matching address interrupts
    wake_en_i = 1'b1;
    base = n_irq;
    m_req(twb_pkg::TWB_OP_REL, 8'h00, 1'b0);
    m_req(twb_pkg::TWB_OP_WORD, 8'h11, 1'b0);
    chk("wake miss", 8'(n_irq - base), 8'h00);
    m_req(twb_pkg::TWB_OP_REL, 8'h00, 1'b0);
    m_req(twb_pkg::TWB_OP_WORD, 8'h5a, 1'b0);
    chk("wake hit", 8'(n_irq - base), 8'h01);
    wake_en_i = 1'b0;
    // drain whatever wake mode kept
    rx_ready_i = 1'b1;
    repeat (12) @(negedge clock_i);
    rx_ready_i = 1'b0;
    // busy keeps the clock running until released
    busy_en_i = 1'b1;
    fork
      m_req(twb_pkg::TWB_OP_WORD, 8'h42, 1'b0);
      begin
        repeat (200) @(negedge clock_i);
        chk("busy holds", got_done, 8'h00);
        chk("busy clocks", 8'(nbits > 20), 8'h01);
        busy_en_i = 1'b0;
      end
    join
    nb = nbits;
    repeat (40) @(negedge clock_i);
    chk("clock stopped", 8'(nbits - nb), 8'h00);
    pop(twb_pkg::TWB_K_DATA, 8'h42);
    // fill the fifo: the full word stalls until a pop
    for (int i = 0; i < 7; i++) begin
      m_req(twb_pkg::TWB_OP_WORD, 8'(8'h10 + i), 1'b0);
    end
    fork
      m_req(twb_pkg::TWB_OP_WORD, 8'h17, 1'b0);
      begin
        repeat (150) @(negedge clock_i);
        chk("full stalls", got_done, 8'h00);
        pop(twb_pkg::TWB_K_DATA, 8'h10);
      end
    join
    for (int i = 1; i < 8; i++) begin
      pop(twb_pkg::TWB_K_DATA, 8'(8'h10 + i));
    end
    chk("no drops", 8'(n_drop), 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
